//--- inc/ctit_pkg.sv
// Constants, register map and state layout of the carrier timer and the interval timer.
// Behaviour
// [R1] Carrier timer interrupt pending clears itself by hardware when serviced.
// [R2] Carrier timer as interval timer interrupts once per programmed interval.
// [R3] Start level 0: low lasts low reload plus 2, high lasts high reload plus 2.
// [R4] Start level 1: low lasts high reload plus 2, high lasts low reload plus 2.
// [R5] Repeat mode alternates low and high periods continuously.
// [R6] One-shot mode emits one pulse; software keeps the low reload nonzero.
// [R7] One-shot output edge follows the start after a short fixed latency; the code gives the first edge low reload plus 2 ticks after the start.
// [R8] Interval clock selects main clock /256, /64, /8, /1 or carrier flip-flop.
// [R9] Interval timer has 16-bit counter, comparator and split 16-bit reference.
// [R10] On count equal reference: match interrupt, counter cleared, counting continues.
// [R11] Match interrupt is requested on level 2 with its own vector.
// [R12] Servicing the match interrupt clears its pending flag automatically.
// [R13] Pending bit 0 sets on match even when disabled; software clears writing 0.
// [R14] Writing 1 to control bit 3 clears the counter at any time.
// [R15] Software sets control bits 2 and 1 to get match interrupts.
// [R16] Interval control resets to 00: counting off, carrier clock, interrupt off.
// [R17] Software should clear counter and pending when starting for exact interval.
// [R18] Carrier reloads are 8-bit, writable anytime, used at the next reload.
// [R19] Counters advance once per selected clock tick and hold while disabled.
package ctit_pkg;

	localparam logic [7:0] ADDR_CAR_CTRL  = 8'hE0;
	localparam logic [7:0] ADDR_CAR_HIGH  = 8'hE1;
	localparam logic [7:0] ADDR_CAR_LOW   = 8'hE2;
	localparam logic [7:0] ADDR_INT_CTRL  = 8'hE3;
	localparam logic [7:0] ADDR_INT_CNTH  = 8'hE4;
	localparam logic [7:0] ADDR_INT_CNTL  = 8'hE5;
	localparam logic [7:0] ADDR_INT_REFH  = 8'hE6;
	localparam logic [7:0] ADDR_INT_REFL  = 8'hE7;

	// carrier control fields
	localparam int CAR_ONESHOT_BIT = 0;
	localparam int CAR_START_BIT   = 1;
	localparam int CAR_RUN_BIT     = 2;
	localparam int CAR_IE_BIT      = 3;
	localparam int CAR_CLK_LSB     = 4;

	// interval control fields
	localparam int INT_PEND_BIT = 0;
	localparam int INT_IE_BIT   = 1;
	localparam int INT_RUN_BIT  = 2;
	localparam int INT_CLR_BIT  = 3;
	localparam int INT_SEL_LSB  = 4;

	localparam logic [7:0] CAR_CTRL_RESET = 8'h00;
	localparam logic [7:0] INT_CTRL_RESET = 8'h00;

	// interval clock select codes
	localparam logic [2:0] SEL_CARRIER = 3'h0;
	localparam logic [2:0] SEL_DIV256  = 3'h1;
	localparam logic [2:0] SEL_DIV64   = 3'h2;
	localparam logic [2:0] SEL_DIV8    = 3'h3;
	localparam logic [2:0] SEL_DIV1    = 3'h4;

	// divider shift for each prescaled tick
	localparam logic [3:0] SHIFT_256 = 4'h8;
	localparam logic [3:0] SHIFT_64  = 4'h6;
	localparam logic [3:0] SHIFT_8   = 4'h3;
	localparam logic [3:0] SHIFT_1   = 4'h0;

	localparam logic [8:0] PERIOD_EXTRA = 9'h001;
	localparam logic [1:0] INT_IRQ_LEVEL  = 2'h2;
	localparam logic [7:0] INT_IRQ_VECTOR = 8'hE2;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic       write;
		logic       read;
	} ctit_reg_req_t;

	typedef struct packed {
		logic [7:0]  div;
		logic        carOneShot;
		logic        carStartLvl;
		logic        carRun;
		logic        carIe;
		logic [1:0]  carClk;
		logic [7:0]  carHigh;
		logic [7:0]  carLow;
		logic [7:0]  carCur;
		logic [8:0]  carCnt;
		logic        carFf;
		logic        carPend;
		logic [2:0]  intSel;
		logic        intRun;
		logic        intIe;
		logic        intPend;
		logic [15:0] intRef;
		logic [15:0] intCnt;
		logic        ffPrev;
		logic [7:0]  rdData;
	} ctit_state_t;

endpackage : ctit_pkg

//--- logic/ctit_timer.sv
// Carrier/pulse timer driving an output flip-flop, and 16-bit interval timer it can clock.
`timescale 1ns/10ps
module ctit_timer (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire ctit_pkg::ctit_reg_req_t regReq,
	output logic [7:0]                  regRdData,
	input  wire logic                   carrierIrqAck,
	input  wire logic                   intervalIrqAck,
	output logic                        carrierIrq,
	output logic                        intervalMatchIrq,
	output logic [1:0]                  intervalIrqLevel,
	output logic [7:0]                  intervalIrqVector,
	output logic                        carrierOutputPin
);
	import ctit_pkg::*;

	ctit_state_t st;
	ctit_state_t next_st;

	logic       carTick;
	logic       carToggle;
	logic       carEvt;
	logic       intTick;
	logic       intEvt;
	logic       wrCarCtrl;
	logic       wrIntCtrl;
	logic [7:0] readMux;

	// true on the divider count that closes a 2^shift period
	function automatic logic divTick(input logic [7:0] d, input logic [3:0] shift);
		logic [8:0] mask;
		mask = (9'h001 << shift) - 9'h001;
		return (d & mask[7:0]) == mask[7:0];
	endfunction : divTick

	////////////////////////////////////////////////////////////////////////////////
	// ticks and events

	assign carTick   = divTick(st.div, {2'h0, st.carClk}) && st.carRun;              // R19
	assign carToggle = carTick && (st.carCnt == {1'b0, st.carCur} + PERIOD_EXTRA);   // R3 R4
	assign carEvt    = carToggle && (st.carFf != st.carStartLvl);                    // R2
	assign wrCarCtrl = regReq.write && (regReq.addr == ADDR_CAR_CTRL);
	assign wrIntCtrl = regReq.write && (regReq.addr == ADDR_INT_CTRL);

	always_comb begin
		intTick = 1'b0;
		case (st.intSel)                                                           // R8
			SEL_CARRIER: intTick = st.carFf && !st.ffPrev;
			SEL_DIV256:  intTick = divTick(st.div, SHIFT_256);
			SEL_DIV64:   intTick = divTick(st.div, SHIFT_64);
			SEL_DIV8:    intTick = divTick(st.div, SHIFT_8);
			SEL_DIV1:    intTick = divTick(st.div, SHIFT_1);
			default:     intTick = 1'b0;
		endcase
		intTick = intTick && st.intRun;                                            // R19
	end

	assign intEvt = intTick && (st.intCnt == st.intRef);                           // R9 R10

	always_comb begin
		case (regReq.addr)
			ADDR_CAR_CTRL: readMux = {2'h0, st.carClk, st.carIe, st.carRun, st.carStartLvl, st.carOneShot};
			ADDR_CAR_HIGH: readMux = st.carHigh;
			ADDR_CAR_LOW:  readMux = st.carLow;
			ADDR_INT_CTRL: readMux = {1'b0, st.intSel, 1'b0, st.intRun, st.intIe, st.intPend};
			ADDR_INT_CNTH: readMux = st.intCnt[15:8];
			ADDR_INT_CNTL: readMux = st.intCnt[7:0];
			ADDR_INT_REFH: readMux = st.intRef[15:8];
			ADDR_INT_REFL: readMux = st.intRef[7:0];
			default:       readMux = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st        = st;
		next_st.div    = st.div + 8'h01;
		next_st.ffPrev = st.carFf;

		// carrier phase counter; reload latched at each phase start
		if (carToggle) begin
			next_st.carCnt = 9'h000;
			next_st.carFf  = !st.carFf;
			next_st.carCur = (!st.carFf == st.carStartLvl) ? st.carLow : st.carHigh;   // R4 R18
			if (carEvt && st.carOneShot) begin
				next_st.carRun = 1'b0;                                                   // R6
			end
		end else if (carTick) begin
			next_st.carCnt = st.carCnt + 9'h001;                                         // R5
		end

		if (intTick) begin
			next_st.intCnt = intEvt ? 16'h0000 : st.intCnt + 16'h0001;                   // R10
		end

		if (regReq.write) begin
			case (regReq.addr)
				ADDR_CAR_CTRL: begin
					next_st.carOneShot  = regReq.wrData[CAR_ONESHOT_BIT];
					next_st.carStartLvl = regReq.wrData[CAR_START_BIT];
					next_st.carRun      = regReq.wrData[CAR_RUN_BIT];
					next_st.carIe       = regReq.wrData[CAR_IE_BIT];
					next_st.carClk      = regReq.wrData[CAR_CLK_LSB +: 2];
					// a fresh start restarts the phase; a stopped timer parks at start level
					if (!st.carRun || !regReq.wrData[CAR_RUN_BIT]) begin
						next_st.carCnt = 9'h000;
						next_st.carFf  = regReq.wrData[CAR_START_BIT];                       // R7
						next_st.carCur = st.carLow;
					end
				end
				ADDR_CAR_HIGH: next_st.carHigh = regReq.wrData;                          // R18
				ADDR_CAR_LOW:  next_st.carLow  = regReq.wrData;                          // R18
				ADDR_INT_CTRL: begin
					next_st.intSel = regReq.wrData[INT_SEL_LSB +: 3];
					next_st.intRun = regReq.wrData[INT_RUN_BIT];
					next_st.intIe  = regReq.wrData[INT_IE_BIT];
					if (regReq.wrData[INT_CLR_BIT]) begin
						next_st.intCnt = 16'h0000;                                           // R14
					end
					if (!regReq.wrData[INT_PEND_BIT]) begin
						next_st.intPend = 1'b0;                                              // R13
					end
				end
				ADDR_INT_CNTH: next_st.intCnt[15:8] = regReq.wrData;
				ADDR_INT_CNTL: next_st.intCnt[7:0]  = regReq.wrData;
				ADDR_INT_REFH: next_st.intRef[15:8] = regReq.wrData;                     // R9
				ADDR_INT_REFL: next_st.intRef[7:0]  = regReq.wrData;                     // R9
				default: ;
			endcase
		end

		// set wins over any clear landing in the same cycle
		if (carrierIrqAck) begin
			next_st.carPend = 1'b0;                                                      // R1
		end
		if (carEvt) begin
			next_st.carPend = 1'b1;                                                      // R2
		end
		if (intervalIrqAck) begin
			next_st.intPend = 1'b0;                                                      // R12
		end
		if (intEvt) begin
			next_st.intPend = 1'b1;                                                      // R10 R13
		end

		if (regReq.read) begin
			next_st.rdData = readMux;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st             <= '0;
			st.carOneShot  <= CAR_CTRL_RESET[CAR_ONESHOT_BIT];
			st.carStartLvl <= CAR_CTRL_RESET[CAR_START_BIT];
			st.intSel      <= INT_CTRL_RESET[INT_SEL_LSB +: 3];                         // R16
			st.intRun      <= INT_CTRL_RESET[INT_RUN_BIT];                              // R16
			st.intIe       <= INT_CTRL_RESET[INT_IE_BIT];                               // R16
		end else begin
			st <= next_st;
		end
	end

	assign regRdData         = st.rdData;
	assign carrierOutputPin  = st.carFf;
	assign carrierIrq        = st.carPend && st.carIe;
	assign intervalMatchIrq  = st.intPend && st.intIe && st.intRun;                 // R11 R15
	assign intervalIrqLevel  = INT_IRQ_LEVEL;                                       // R11
	assign intervalIrqVector = INT_IRQ_VECTOR;                                      // R11

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// selected ticks seen since the phase began, for period checks
	logic [9:0] phaseTicks;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phaseTicks <= 10'h000;
		end else if (carToggle || (wrCarCtrl && (!st.carRun || !regReq.wrData[CAR_RUN_BIT]))) begin
			// a control write that keeps a running timer running keeps the phase going; any other control write restarts the count
			phaseTicks <= 10'h000;
		end else if (carTick) begin
			phaseTicks <= phaseTicks + 10'h001;
		end
	end

	carrier_pend_clear_a: assert property (carrierIrqAck && !carEvt |=> !st.carPend) // R1
		else $error("carrier pending not cleared by service");
	carrier_interval_irq_a: assert property (carEvt |=> st.carPend) // R2
		else $error("carrier interval did not set pending");
	// ticks before the closing one; the closing tick itself makes reload plus 2
	carrier_period_len_a: assert property (carToggle |-> phaseTicks + 10'h001 == {2'h0, st.carCur} + 10'h002 && phaseTicks == {2'h0, st.carCnt}) // R3
		else $error("carrier phase length wrong");
	carrier_reload_pick_a: assert property (carToggle && !wrCarCtrl |=> st.carCur == ((st.carFf == st.carStartLvl) ? $past(st.carLow) : $past(st.carHigh))) // R4
		else $error("carrier phase took wrong reload");
	carrier_repeat_a: assert property (carEvt && !st.carOneShot && !wrCarCtrl |=> st.carRun && st.carFf == st.carStartLvl) // R5
		else $error("repeat mode stopped");
	carrier_oneshot_a: assert property (carEvt && st.carOneShot && !wrCarCtrl |=> !st.carRun ##1 $stable(st.carFf)) // R6
		else $error("one-shot did not stop");
	carrier_start_a: assert property (wrCarCtrl && !st.carRun && regReq.wrData[CAR_RUN_BIT] |=> st.carFf == $past(regReq.wrData[CAR_START_BIT]) && st.carCnt == 9'h000) // R7
		else $error("one-shot start not aligned");
	interval_div8_a: assert property (intTick && st.intSel == SEL_DIV8 |=> (!intTick || st.intSel != SEL_DIV8)[*7]) // R8
		else $error("divide by 8 tick spacing wrong");
	interval_match_a: assert property (intEvt && !regReq.write |=> st.intCnt == 16'h0000 && st.intPend) // R10
		else $error("match did not clear counter");
	interval_pend_clr_a: assert property (intervalIrqAck && !intEvt |=> !st.intPend) // R12
		else $error("service did not clear pending");
	interval_pend_dis_a: assert property (intEvt && !st.intIe && !wrIntCtrl |=> st.intPend && !intervalMatchIrq) // R13
		else $error("pending not set while disabled");
	interval_clear_a: assert property (wrIntCtrl && regReq.wrData[INT_CLR_BIT] |=> st.intCnt == 16'h0000) // R14
		else $error("counter clear ignored");
	interval_hold_a: assert property (!st.intRun && !regReq.write |=> $stable(st.intCnt) && !intEvt) // R19
		else $error("disabled counter moved");

endmodule : ctit_timer

//--- testbench/tb.sv
// Self-checking bench for the carrier timer and the interval timer.
`timescale 1ns/10ps
module tb;
	import ctit_pkg::*;

	logic                    clk;
	logic                    resetn;
	ctit_pkg::ctit_reg_req_t regReq;
	logic [7:0]              regRdData;
	logic                    carAck;
	logic                    intAck;
	logic                    carrierIrq;
	logic                    intervalMatchIrq;
	logic [1:0]              intervalIrqLevel;
	logic [7:0]              intervalIrqVector;
	logic                    carrierOutputPin;
	int                      n_fail;
	int                      num_checks;
	logic [7:0]              rdVal;
	logic [7:0]              rdPrev;

	ctit_timer DUT (
		.clk              (clk),
		.resetn           (resetn),
		.regReq           (regReq),
		.regRdData        (regRdData),
		.carrierIrqAck    (carAck),
		.intervalIrqAck   (intAck),
		.carrierIrq       (carrierIrq),
		.intervalMatchIrq (intervalMatchIrq),
		.intervalIrqLevel (intervalIrqLevel),
		.intervalIrqVector(intervalIrqVector),
		.carrierOutputPin (carrierOutputPin)
	);

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one idle cycle between accesses keeps every strobe edge in its own time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regReq.addr = a;
		regReq.wrData = d;
		regReq.write = 1'b1;
		@(posedge clk);
		#1;
		regReq.write = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		regReq.addr = a;
		regReq.read = 1'b1;
		@(posedge clk);
		#1;
		regReq.read = 1'b0;
		d = regRdData;
	endtask : rd

	task automatic run_len(output int n);
		logic v;
		v = carrierOutputPin;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (carrierOutputPin === v && n < 600);
	endtask : run_len

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(ADDR_INT_CTRL, rdVal);
		chk(rdVal, 8'h00);
		rd(8'h10, rdVal);
		chk(rdVal, 8'h00);
		chk(intervalIrqLevel, 2'h2);
		chk(intervalIrqVector, 8'hE2);
	endtask : t_reset

	task automatic t_car_repeat(input logic s, input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] c);
		int n;
		wr(ADDR_CAR_LOW, lo);
		wr(ADDR_CAR_HIGH, hi);
		wr(ADDR_CAR_CTRL, 8'h0C | {2'h0, c, 2'h0, s, 1'b0});
		for (n = 0; n < 600 && carrierOutputPin !== s; n++) begin @(posedge clk); #1; end
		for (n = 0; n < 600 && carrierOutputPin === s; n++) begin @(posedge clk); #1; end
		// phases after the first start on a prescaler tick, so each is exact in clocks
		run_len(n);
		chk(16'(n), ({8'h00, hi} + 16'h0002) << c);
		run_len(n);
		chk(16'(n), ({8'h00, lo} + 16'h0002) << c);
		run_len(n);
		chk(16'(n), ({8'h00, hi} + 16'h0002) << c);
		for (n = 0; n < 600 && carrierIrq !== 1'b1; n++) begin @(posedge clk); #1; end
		chk(carrierIrq, 1'b1);
		carAck = 1'b1;
		@(posedge clk);
		#1;
		carAck = 1'b0;
		chk(carrierIrq, 1'b0);
		wr(ADDR_CAR_CTRL, 8'h00);
	endtask : t_car_repeat

	task automatic t_one_shot();
		int n;
		wr(ADDR_CAR_LOW, 8'h01);
		wr(ADDR_CAR_HIGH, 8'h04);
		wr(ADDR_CAR_CTRL, 8'h05);
		for (n = 0; n < 20 && carrierOutputPin !== 1'b1; n++) begin @(posedge clk); #1; end
		// start phase runs on the low reload of 1, so 3 ticks
		chk(16'(n), 16'h0003);
		run_len(n);
		chk(16'(n), 16'h0006);
		repeat (20) @(posedge clk);
		#1;
		chk(carrierOutputPin, 1'b0);
		rd(ADDR_CAR_CTRL, rdVal);
		chk(rdVal, 8'h01);
	endtask : t_one_shot

	task automatic t_int_period(input logic [2:0] sel, input logic [7:0] rf, input int exp);
		int n;
		wr(ADDR_INT_REFH, 8'h00);
		wr(ADDR_INT_REFL, rf);
		wr(ADDR_INT_CTRL, {1'b0, sel, 4'hE});
		for (n = 0; n < 1200 && intervalMatchIrq !== 1'b1; n++) begin @(posedge clk); #1; end
		intAck = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			intAck = 1'b0;
			n++;
			if (n == 1) chk(intervalMatchIrq, 1'b0);
		end while (intervalMatchIrq !== 1'b1 && n < 1200);
		chk(16'(n), 16'(exp));
		wr(ADDR_INT_CTRL, 8'h00);
	endtask : t_int_period

	task automatic t_int_masked();
		wr(ADDR_INT_REFL, 8'h03);
		wr(ADDR_INT_CTRL, 8'h4C);
		// keeps the write-0 clear below off a match edge, where the match would win
		repeat (9) @(posedge clk);
		#1;
		chk(intervalMatchIrq, 1'b0);
		rd(ADDR_INT_CTRL, rdVal);
		chk(rdVal, 8'h45);
		wr(ADDR_INT_CTRL, 8'h40);
		rd(ADDR_INT_CTRL, rdVal);
		chk(rdVal, 8'h40);
		wr(ADDR_INT_CNTL, 8'h33);
		rd(ADDR_INT_CNTL, rdPrev);
		repeat (5) @(posedge clk);
		rd(ADDR_INT_CNTL, rdVal);
		chk(rdPrev, 8'h33);
		chk(rdVal, 8'h33);
		wr(ADDR_INT_CTRL, 8'h48);
		rd(ADDR_INT_CNTL, rdVal);
		chk(rdVal, 8'h00);
		// select codes above the divider taps give no clock at all
		wr(ADDR_INT_CTRL, 8'h5C);
		repeat (6) @(posedge clk);
		rd(ADDR_INT_CNTL, rdVal);
		chk(rdVal, 8'h00);
	endtask : t_int_masked

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		regReq = '0;
		carAck = 1'b0;
		intAck = 1'b0;
		n_fail = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_car_repeat(1'b0, 8'h05, 8'h03, 2'h0);
		t_car_repeat(1'b1, 8'h02, 8'h07, 2'h0);
		// divide by 8 carrier clock stretches every phase eightfold
		t_car_repeat(1'b0, 8'h01, 8'h02, 2'h3);
		t_one_shot();
		t_int_period(SEL_DIV1, 8'h03, 4);
		t_int_period(SEL_DIV1, 8'h01, 2);
		t_int_period(SEL_DIV8, 8'h01, 16);
		t_int_period(SEL_DIV64, 8'h01, 128);
		t_int_period(SEL_DIV256, 8'h01, 512);
		// carrier at 1/1 reloads gives a 6-cycle flip-flop period as the tick source
		wr(ADDR_CAR_LOW, 8'h01);
		wr(ADDR_CAR_HIGH, 8'h01);
		wr(ADDR_CAR_CTRL, 8'h04);
		t_int_period(SEL_CARRIER, 8'h01, 12);
		wr(ADDR_CAR_CTRL, 8'h00);
		t_int_masked();
		test_done();
	end

	// the full sequence needs well under 10k cycles
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
endmodule : tb
